// ---- pcf_command_filter.sv ----
// Command acceptance and issue filter of a two-port PCI bridge, one side per instance.
// Operation
// - Two 128-byte write buffers, upstream and downstream.
// - Four further 128-byte buffers for reads.
// - Reserved commands never issued, ignored as target.
// - Interrupt acknowledge never issued, always ignored.
// - Special cycles issued but never claimed.
// - Memory, I/O, DAC commands issued and claimed both.
// - Config read issued secondary, claimed primary only.
// - Config write: Type 1 primary issue, Type 1 secondary claim.
// - No Type 0 out primary, none claimed secondary.
// - Misaligned burst disconnects after first transfer.
// - Claim only by positive medium decode.
`timescale 1ns/1ps
`include "pcf_params.svh"

module pcf_command_filter #(
  // Buffer geometry; only the sizes are reported here, the storage lives in the queue logic.
  parameter int BUF_BYTES = `PCF_BUF_BYTES,
  parameter int WR_BUFS = `PCF_WR_BUFS,
  parameter int RD_BUFS = `PCF_RD_BUFS
) (
  input wire logic CLK_SYS,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  // High when this instance faces the secondary bus.
  input wire logic SIDE_SEC,
  // Target side: address phase sampled from the bus.
  input wire logic ADDR_VALID,
  input wire logic [3:0] ADDR_CMD,
  input wire logic [1:0] ADDR_LOW,
  input wire logic ADDR_HIT,
  input wire logic FRAME_DONE,
  input wire logic DATA_XFER,
  // Master side: a request to issue a command on this bus.
  input wire logic ISSUE_REQ,
  input wire logic [3:0] ISSUE_CMD,
  input wire logic [1:0] ISSUE_LOW,
  output logic ISSUE_OK,
  output logic CLAIM,
  output logic DEVSEL_OE,
  output logic DISCONNECT,
  output logic [3:0] CLAIM_CMD,
  output logic [7:0] WR_BUF_BYTES,
  output logic [9:0] RD_BUF_BYTES
);

  // --------------------------------------------------------------------------
  // Command classification
  // --------------------------------------------------------------------------
  // Returns high for commands that may be claimed as target on this side.
  function automatic logic pcf_target_ok(input logic [3:0] cmd, input logic sec, input logic [1:0] low);
    logic ok;
    ok = 1'b0;
    case (cmd)
      `PCF_CMD_IO_RD, `PCF_CMD_IO_WR, `PCF_CMD_MEM_RD, `PCF_CMD_MEM_WR,
      `PCF_CMD_MEM_RDM, `PCF_CMD_DAC, `PCF_CMD_MEM_RDL, `PCF_CMD_MEM_WRI: ok = 1'b1;
      `PCF_CMD_CFG_RD: ok = !sec;
      `PCF_CMD_CFG_WR: ok = !sec || low[`PCF_CFG_TYPE_LSB];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Returns high for commands that may be issued as master on this side.
  function automatic logic pcf_master_ok(input logic [3:0] cmd, input logic sec, input logic [1:0] low);
    logic ok;
    ok = 1'b0;
    case (cmd)
      `PCF_CMD_SPECIAL: ok = 1'b1;
      `PCF_CMD_IO_RD, `PCF_CMD_IO_WR, `PCF_CMD_MEM_RD, `PCF_CMD_MEM_WR,
      `PCF_CMD_MEM_RDM, `PCF_CMD_DAC, `PCF_CMD_MEM_RDL, `PCF_CMD_MEM_WRI: ok = 1'b1;
      `PCF_CMD_CFG_RD: ok = sec;
      `PCF_CMD_CFG_WR: ok = sec || low[`PCF_CFG_TYPE_LSB];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // --------------------------------------------------------------------------
  // Decode wires
  // --------------------------------------------------------------------------
  // Issue check is combinational so the master engine can gate its request at once.
  wire issue_allowed = pcf_master_ok(ISSUE_CMD, SIDE_SEC, ISSUE_LOW);
  wire target_allowed = pcf_target_ok(ADDR_CMD, SIDE_SEC, ADDR_LOW);
  wire claim_now = ADDR_HIT && target_allowed;
  wire burst_misaligned = |ADDR_LOW[`PCF_BURST_LO_MSB:0];
  // Config cycles use the low bits as type, not burst order.
  wire is_cfg = (ADDR_CMD == `PCF_CMD_CFG_RD) || (ADDR_CMD == `PCF_CMD_CFG_WR);
  assign ISSUE_OK = ISSUE_REQ && issue_allowed;
  // Buffer capacity is fixed by structure and reported for the queue logic.
  assign WR_BUF_BYTES = 8'(BUF_BYTES);
  assign RD_BUF_BYTES = 10'(BUF_BYTES * RD_BUFS);

  // --------------------------------------------------------------------------
  // Target claim sequencer
  // --------------------------------------------------------------------------
  // Frame bookkeeping: the latched command, its misalignment and the claim decision.
  pcf_pkg::pcf_state_e state_reg, state_next;
  logic [3:0] cmd_reg, cmd_next;
  logic misalign_reg, misalign_next;
  logic claim_reg, claim_next;

  // Medium decode: the address phase is latched, and select rises on that same edge.
  always_comb begin
    state_next = state_reg;
    cmd_next = cmd_reg;
    misalign_next = misalign_reg;
    claim_next = claim_reg;
    case (state_reg)
      pcf_pkg::PCF_IDLE: begin
        claim_next = 1'b0;
        if (ADDR_VALID) begin
          cmd_next = ADDR_CMD;
          misalign_next = burst_misaligned && !is_cfg;
          claim_next = claim_now;
          state_next = pcf_pkg::PCF_DECODE;
        end
      end
      pcf_pkg::PCF_DECODE: begin
        // An ignored command waits out the frame with select never raised.
        state_next = pcf_pkg::PCF_BUSY;
        if (FRAME_DONE) begin
          state_next = pcf_pkg::PCF_IDLE;
          claim_next = 1'b0;
        end
      end
      pcf_pkg::PCF_BUSY: begin
        if (FRAME_DONE) begin
          state_next = pcf_pkg::PCF_IDLE;
          claim_next = 1'b0;
        end
      end
      default: state_next = pcf_pkg::PCF_IDLE;
    endcase
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= pcf_pkg::PCF_IDLE;
      cmd_reg <= `PCF_CMD_NONE;
      misalign_reg <= 1'b0;
      claim_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      cmd_reg <= cmd_next;
      misalign_reg <= misalign_next;
      claim_reg <= claim_next;
    end
  end

  // Outputs driven only while a claimed frame is in progress.
  wire in_frame = (state_reg != pcf_pkg::PCF_IDLE);
  assign CLAIM = claim_reg && in_frame;
  assign DEVSEL_OE = CLAIM;
  // The command output reads as the idle code whenever nothing is claimed, so a stale code never leaks.
  assign CLAIM_CMD = CLAIM ? cmd_reg : `PCF_CMD_NONE;
  // Disconnect is combinational so that it lands on the very data phase that moves the first word.
  assign DISCONNECT = CLAIM && misalign_reg && DATA_XFER;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  // Issue-side checks act on the combinational answer in the same cycle.
  // Checks that span edges are switched off while the clock enable freezes the block.
  chk_reserved_never_issued: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    ISSUE_OK |-> !(ISSUE_CMD inside {`PCF_CMD_RSV4, `PCF_CMD_RSV5, `PCF_CMD_RSV8, `PCF_CMD_RSV9}))
    else $error("Reserved command allowed to issue.");
  chk_intack_never_issued: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    ISSUE_OK |-> ISSUE_CMD != `PCF_CMD_INTACK)
    else $error("Interrupt acknowledge allowed to issue.");
  chk_special_not_claimed: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    CLAIM |-> !(cmd_reg inside {`PCF_CMD_SPECIAL, `PCF_CMD_INTACK, `PCF_CMD_RSV4, `PCF_CMD_RSV9}))
    else $error("Unsupported command claimed.");
  // Target-side checks except chk_special_not_claimed, chk_cfg_rd_side and chk_claim_released start at the address phase, so a broken claim cannot hide.
  chk_mem_claimed: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (state_reg == pcf_pkg::PCF_IDLE && ADDR_VALID && ADDR_HIT && ADDR_CMD == `PCF_CMD_MEM_WR) |=> CLAIM)
    else $error("Memory write not claimed one cycle after decode.");
  chk_cfg_rd_side: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (CLAIM && cmd_reg == `PCF_CMD_CFG_RD) |-> !SIDE_SEC)
    else $error("Config read claimed on secondary.");
  chk_cfg_type0_primary: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (ISSUE_OK && ISSUE_CMD == `PCF_CMD_CFG_WR && !SIDE_SEC) |-> ISSUE_LOW[`PCF_CFG_TYPE_LSB])
    else $error("Type 0 config write issued on primary.");
  chk_cfg_rd_issue: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (ISSUE_OK && ISSUE_CMD == `PCF_CMD_CFG_RD) |-> SIDE_SEC)
    else $error("Config read issued on primary.");
  chk_no_subtractive: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (state_reg == pcf_pkg::PCF_IDLE && ADDR_VALID && !ADDR_HIT) |=> !CLAIM [*2])
    else $error("Claim without positive decode hit.");
  chk_ignored_quiet: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (state_reg == pcf_pkg::PCF_IDLE && ADDR_VALID && ADDR_CMD == `PCF_CMD_RSV8) |=> !DEVSEL_OE && !DISCONNECT)
    else $error("Target outputs raised for an ignored command.");
  chk_misalign_disc: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (state_reg == pcf_pkg::PCF_IDLE && ADDR_VALID && ADDR_HIT && ADDR_CMD == `PCF_CMD_MEM_RDL
      && ADDR_LOW != 2'h0) ##1 !FRAME_DONE ##1 DATA_XFER |-> DISCONNECT)
    else $error("Misaligned burst not disconnected.");
  chk_type0_sec_ignored: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (state_reg == pcf_pkg::PCF_IDLE && ADDR_VALID && SIDE_SEC && ADDR_CMD == `PCF_CMD_CFG_WR
      && !ADDR_LOW[`PCF_CFG_TYPE_LSB]) |=> !CLAIM)
    else $error("Type 0 config write claimed on secondary.");
  chk_cfg_wr_primary: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (state_reg == pcf_pkg::PCF_IDLE && ADDR_VALID && ADDR_HIT && !SIDE_SEC
      && ADDR_CMD == `PCF_CMD_CFG_WR) |=> CLAIM)
    else $error("Config write not claimed on primary.");
  chk_special_issued: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
    (ISSUE_REQ && ISSUE_CMD == `PCF_CMD_SPECIAL) |-> ISSUE_OK)
    else $error("Special cycle refused as master.");
  chk_claim_released: assert property (@(posedge CLK_SYS) disable iff (!RESET_N || !CLK_EN)
    (CLAIM && FRAME_DONE) |=> !CLAIM && !DEVSEL_OE)
    else $error("Target select held after frame end.");

  // --------------------------------------------------------------------------
  // Cover points
  // --------------------------------------------------------------------------
  // Each cover marks one main scenario, so a bench that skips it shows up at once.
  cov_mem_claim: cover property (@(posedge CLK_SYS) CLAIM && cmd_reg == `PCF_CMD_MEM_RD);
  cov_cfg_rd_claim: cover property (@(posedge CLK_SYS) CLAIM && cmd_reg == `PCF_CMD_CFG_RD);
  cov_disconnect: cover property (@(posedge CLK_SYS) DISCONNECT);
  cov_cfg_wr_sec: cover property (@(posedge CLK_SYS) CLAIM && SIDE_SEC && cmd_reg == `PCF_CMD_CFG_WR);
  cov_special_issue: cover property (@(posedge CLK_SYS) ISSUE_OK && ISSUE_CMD == `PCF_CMD_SPECIAL);

endmodule

// ---- pcf_params.svh ----
// Constants for the bridge command filter: command codes, buffer sizes and field positions.
`ifndef PCF_PARAMS_SVH
`define PCF_PARAMS_SVH

// ----------------------------------------------------------------------------
// Bus command codes
// ----------------------------------------------------------------------------
`define PCF_CMD_INTACK 4'h0
`define PCF_CMD_SPECIAL 4'h1
`define PCF_CMD_IO_RD 4'h2
`define PCF_CMD_IO_WR 4'h3
`define PCF_CMD_RSV4 4'h4
`define PCF_CMD_RSV5 4'h5
`define PCF_CMD_MEM_RD 4'h6
`define PCF_CMD_MEM_WR 4'h7
`define PCF_CMD_RSV8 4'h8
`define PCF_CMD_RSV9 4'h9
`define PCF_CMD_CFG_RD 4'ha
`define PCF_CMD_CFG_WR 4'hb
`define PCF_CMD_MEM_RDM 4'hc
`define PCF_CMD_DAC 4'hd
`define PCF_CMD_MEM_RDL 4'he
`define PCF_CMD_MEM_WRI 4'hf
// Code shown on the command output while nothing is claimed.
`define PCF_CMD_NONE 4'h0

// ----------------------------------------------------------------------------
// Buffer sizing and address fields
// ----------------------------------------------------------------------------
`define PCF_BUF_BYTES 128
`define PCF_WR_BUFS 2
`define PCF_RD_BUFS 4
`define PCF_CFG_TYPE_LSB 0
`define PCF_BURST_LO_MSB 1
`define PCF_DEC_DELAY 2

`endif

// ---- pcf_pkg.sv ----
// Types shared by the bridge command filter.
package pcf_pkg;
  typedef enum logic [1:0] {
    PCF_IDLE,
    PCF_DECODE,
    PCF_BUSY
  } pcf_state_e;
  typedef logic [3:0] pcf_cmd_t;
endpackage

// ---- pcf_initiator_model.sv ----
// Behavioural PCI initiator that runs one single-phase frame per call and reports what the target did.
`timescale 1ns/1ps
module pcf_initiator_model (
  input wire logic clk,
  input wire logic claim,
  input wire logic devsel_oe,
  input wire logic disconnect,
  input wire logic [3:0] claim_cmd,
  output logic addr_valid,
  output logic [3:0] addr_cmd,
  output logic [1:0] addr_low,
  output logic addr_hit,
  output logic data_xfer,
  output logic frame_done
);
  // -------------------------------------------------------------------------
  // Frame driver
  // -------------------------------------------------------------------------
  // The bus starts idle, so the target sees no address phase before the first call.
  initial begin
    {addr_valid, addr_cmd, addr_low, addr_hit, data_xfer, frame_done} = '0;
  end

  // Remote special cycles would go out as a Type 1 configuration write; this model only runs local frames.
  task automatic run(input logic [3:0] c, input logic [1:0] l, input logic h, output logic cl, output logic dv,
                     output logic dc, output logic af, output logic [3:0] cc);
    @(posedge clk);
    {addr_valid, addr_cmd, addr_low, addr_hit} <= {1'b1, c, l, h};
    @(posedge clk);
    // Released lines show the inverse, so a target that samples late cannot pass by luck.
    {addr_valid, addr_cmd, addr_low, addr_hit} <= {1'b0, ~c, ~l, ~h};
    @(negedge clk);
    {cl, dv, cc} = {claim, devsel_oe, claim_cmd};
    @(posedge clk);
    {data_xfer, frame_done} <= 2'b11;
    @(negedge clk);
    dc = disconnect;
    @(posedge clk);
    {data_xfer, frame_done} <= 2'b00;
    @(negedge clk);
    af = claim | devsel_oe;
  endtask
endmodule

// ---- pcf_command_filter_tb.sv ----
// Self-checking bench for the bridge command filter: every command on both sides, then awkward cases.
`timescale 1ns/1ps
`include "pcf_params.svh"
module pcf_command_filter_tb;
  logic clk_sys, reset_n, clk_en, side_sec, issue_req, issue_ok, claim, devsel_oe, disconnect;
  logic addr_valid, addr_hit, frame_done, data_xfer, cl, dv, dc, af, exp;
  logic [3:0] addr_cmd, issue_cmd, claim_cmd, cc;
  logic [1:0] addr_low, issue_low;
  logic [7:0] wr_buf_bytes;
  logic [9:0] rd_buf_bytes;
  int n_errors = 0;
  int total_checks = 0;
  // Rows by command: bit 3 issue primary, 2 issue secondary, 1 claim primary, 0 claim secondary.
  localparam logic [3:0] SUPPORT [16] = '{4'h0, 4'hc, 4'hf, 4'hf, 4'h0, 4'h0, 4'hf, 4'hf,
                                         4'h0, 4'h0, 4'h6, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf};

  pcf_command_filter dut (.CLK_SYS(clk_sys), .RESET_N(reset_n), .CLK_EN(clk_en), .SIDE_SEC(side_sec),
    .ADDR_VALID(addr_valid), .ADDR_CMD(addr_cmd), .ADDR_LOW(addr_low), .ADDR_HIT(addr_hit),
    .FRAME_DONE(frame_done), .DATA_XFER(data_xfer), .ISSUE_REQ(issue_req), .ISSUE_CMD(issue_cmd),
    .ISSUE_LOW(issue_low), .ISSUE_OK(issue_ok), .CLAIM(claim), .DEVSEL_OE(devsel_oe),
    .DISCONNECT(disconnect), .CLAIM_CMD(claim_cmd), .WR_BUF_BYTES(wr_buf_bytes), .RD_BUF_BYTES(rd_buf_bytes));
  pcf_initiator_model model (.clk(clk_sys), .claim(claim), .devsel_oe(devsel_oe), .disconnect(disconnect),
    .claim_cmd(claim_cmd), .addr_valid(addr_valid), .addr_cmd(addr_cmd), .addr_low(addr_low),
    .addr_hit(addr_hit), .data_xfer(data_xfer), .frame_done(frame_done));

  // -------------------------------------------------------------------------
  // Clock, compare tasks and expected-support lookup
  // -------------------------------------------------------------------------
  // Free-running 100 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic check_bit(input string what, input logic e, input logic got);
    total_checks++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, e, got);
    end
  endtask

  task automatic check_vec(input string what, input logic [9:0] e, input logic [9:0] got);
    total_checks++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Type 0 configuration writes are neither issued on the primary nor claimed on the secondary.
  function automatic logic legal(input int col, input logic [3:0] c, input logic [1:0] l);
    legal = SUPPORT[c][col] && !(c == `PCF_CMD_CFG_WR && (col == 3 || col == 0) && !l[0]);
  endfunction

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  // Sweep all commands, both sides, aligned or Type 1 low bits, with and without a decode hit.
  initial begin
    {reset_n, side_sec, issue_req, issue_cmd, issue_low} = '0;
    clk_en = 1'b1;
    repeat (8) @(negedge clk_sys) check_bit("CLAIM in reset", 1'b0, claim | devsel_oe);
    @(posedge clk_sys) reset_n <= 1'b1;
    @(negedge clk_sys);
    check_vec("WR_BUF_BYTES", 10'(`PCF_BUF_BYTES), {2'h0, wr_buf_bytes});
    check_vec("RD_BUF_BYTES", 10'(`PCF_BUF_BYTES * `PCF_RD_BUFS), rd_buf_bytes);
    for (int r = 0; r < 128; r++) begin
      @(posedge clk_sys);
      {side_sec, issue_req, issue_cmd, issue_low} <= {r[4], r[6], r[3:0], 1'b0, r[5]};
      @(negedge clk_sys);
      check_bit("ISSUE_OK", r[6] && legal(3 - r[4], r[3:0], {1'b0, r[5]}), issue_ok);
      model.run(r[3:0], {1'b0, r[5]}, r[6], cl, dv, dc, af, cc);
      exp = r[6] && legal(1 - r[4], r[3:0], {1'b0, r[5]});
      check_bit("CLAIM", exp, cl);
      check_bit("DEVSEL_OE", exp, dv);
      check_vec("CLAIM_CMD", exp ? {6'h0, r[3:0]} : 10'h0, {6'h0, cc});
      check_bit("DISCONNECT", exp && r[5] && r[3:1] != 3'h5, dc);
      check_bit("CLAIM after frame", 1'b0, af);
    end
    // A frozen block must not claim; the frame that follows at once must still be served.
    @(posedge clk_sys) clk_en <= 1'b0;
    model.run(`PCF_CMD_MEM_WR, 2'h0, 1'b1, cl, dv, dc, af, cc);
    check_bit("CLAIM frozen", 1'b0, cl);
    @(posedge clk_sys) clk_en <= 1'b1;
    model.run(`PCF_CMD_MEM_RDL, 2'h2, 1'b1, cl, dv, dc, af, cc);
    check_bit("DISCONNECT misaligned", 1'b1, dc & cl);
    // Reset dropped in mid-frame clears the claim at once; the next frame is served normally.
    fork
      model.run(`PCF_CMD_MEM_RD, 2'h0, 1'b1, cl, dv, dc, af, cc);
      begin
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b0;
        @(negedge clk_sys) check_bit("CLAIM in mid reset", 1'b0, claim | devsel_oe);
        @(posedge clk_sys) reset_n <= 1'b1;
      end
    join
    check_bit("CLAIM before mid reset", 1'b1, cl);
    check_bit("CLAIM after mid reset", 1'b0, af);
    model.run(`PCF_CMD_MEM_WR, 2'h0, 1'b1, cl, dv, dc, af, cc);
    check_bit("CLAIM first after reset", 1'b1, cl & dv);
    check_bit("CLAIM released after reset", 1'b0, af);
    stop_test();
  end
endmodule
